// *** rtl/stc_pkg.sv ***
// constants of the sixteen-bit timer/counter: register map, field layout, timing
// assumes an axi4-lite master on the same clock as the timer core
// Contract
// [RQ1] count kept as readable, writable high and low bytes
// [RQ2] count runs up to all ones, wraps to zero
// [RQ3] wrap to zero latches overflow flag, bit 0
// [RQ4] overflow request raised only while enable bit set
// [RQ5] control bit 1 picks external pin or internal clock
// [RQ6] timer mode counts instruction cycles through prescaler
// [RQ7] counter mode counts rising edges through prescaler
// [RQ8] control bit 0 runs or stops the count
// [RQ9] capture/compare reset input clears the count
// [RQ10] oscillator enable forces both oscillator pins to inputs
// [RQ11] bits 5-4 prescale one, two, four, eight
// [RQ12] control bit 3 powers crystal oscillator amplifier
// [RQ13] bit 2 low synchronises external clock, high not
// [RQ14] internal clock ignores the synchronisation bit
// [RQ15] timer input clock is core clock over four
// [RQ16] counter edges from oscillator pin when oscillator enabled
// [RQ17] count write beats simultaneous capture/compare reset
// [RQ18] prescaler precedes optional synchronisation stage
// [RQ19] upper two control bits read zero, ignore writes
package stc_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_COUNT_LO    = 8'h00;
    localparam logic [7:0]  OFS_COUNT_HI    = 8'h04;
    localparam logic [7:0]  OFS_FLAG        = 8'h08;
    localparam logic [7:0]  OFS_IRQ_EN      = 8'h0c;
    localparam logic [7:0]  OFS_CTRL        = 8'h10;
    localparam logic [7:0]  OFS_PORT_DIR    = 8'h14;
    localparam logic [7:0]  OFS_PORT_DATA   = 8'h18;

    localparam int          CTRL_RUN        = 0;
    localparam int          CTRL_CS         = 1;
    localparam int          CTRL_SYNC_DIS   = 2;
    localparam int          CTRL_OSC_EN     = 3;
    localparam int          CTRL_PSC_LO     = 4;
    localparam int          CTRL_PSC_HI     = 5;
    localparam logic [7:0]  CTRL_MASK       = 8'h3f;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    localparam int          FLAG_OVF        = 0;
    localparam int          EN_OVF          = 0;
    localparam int          PIN_OSC_IN      = 7;
    localparam int          PIN_OSC_OUT     = 6;
    localparam logic [1:0]  PIN_MASK        = 2'h3;
    localparam logic [7:0]  PORT_DIR_RESET  = 8'hff;
    localparam logic [7:0]  PORT_DATA_RESET = 8'h00;

    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_MAX       = 16'hffff;
    localparam int          INSTR_DIV       = 4;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : stc_pkg

// *** rtl/stc_edge_sync.sv ***
// two-flop synchroniser with rising-edge pulse for one pin
// assumes the pin is asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module stc_edge_sync (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pin and result
    input  wire logic pin,
    output logic      rise
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // first flop feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~prev_ff;
endmodule : stc_edge_sync
`default_nettype wire

// *** rtl/stc_prescaler.sv ***
// power-of-two prescaler on single-cycle tick pulses
// assumes tick_in is a one-cycle pulse on aclk
`timescale 1ns/1ps
`default_nettype none
module stc_prescaler #(
    parameter int CNT_W = 3
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic [1:0] ratio_sel,
    input  wire logic       clear,
    // ticks
    input  wire logic       tick_in,
    output logic            tick_out
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] mask;

    if (CNT_W < 3) begin : g_chk
        $error("prescaler needs at least three bits for 1:8");
    end

    assign mask     = CNT_W'((1 << ratio_sel) - 1); // RQ11
    assign tick_out = tick_in && ((cnt_ff & mask) == mask);

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt_ff <= '0;
        end else if (tick_in) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end
endmodule : stc_prescaler
`default_nettype wire

// *** rtl/stc_timer.sv ***
// sixteen-bit timer/counter with axi4-lite register access
// assumes aclk is the core oscillator clock; pins are asynchronous to it
`timescale 1ns/1ps
`default_nettype none
module stc_timer (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write address
    input  wire logic [stc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                awprot,
    input  wire logic                      awvalid,
    output logic                           awready,
    // axi4-lite write data
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    // axi4-lite write response
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    // axi4-lite read address
    input  wire logic [stc_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                arprot,
    input  wire logic                      arvalid,
    output logic                           arready,
    // axi4-lite read data
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // capture/compare unit
    input  wire logic                      cc_reset,
    // oscillator input pin, shared port bit 7
    input  wire logic                      osc_input_pin_in,
    output logic                           osc_input_pin_out,
    output logic                           osc_input_pin_oe_n,
    // oscillator output pin, shared port bit 6, input side is ext_clock_pin
    input  wire logic                      ext_clock_pin_in,
    output logic                           osc_output_pin_out,
    output logic                           osc_output_pin_oe_n,
    // oscillator amplifier and overflow request
    output logic                           osc_amp_enable,
    output logic                           overflow_irq
);
    localparam int DIV_W = $clog2(stc_pkg::INSTR_DIV);

    // register state
    logic [15:0]                count_ff;
    logic [7:0]                 ctrl_ff;
    logic                       flag_ff;
    logic                       irq_en_ff;
    logic [1:0]                 port_dir_ff;
    logic [1:0]                 port_data_ff;
    logic                       irq_ff;
    logic [1:0]                 pin_oe_n_ff;
    logic [1:0]                 pin_out_ff;

    // bus state
    logic                       aw_held_ff;
    logic                       w_held_ff;
    logic [stc_pkg::ADDR_W-1:0] waddr_ff;
    logic [7:0]                 wbyte_ff;
    logic                       wlane_ff;
    logic                       awready_ff;
    logic                       wready_ff;
    logic                       bvalid_ff;
    logic [1:0]                 bresp_ff;
    logic                       arready_ff;
    logic                       rvalid_ff;
    logic [31:0]                rdata_ff;
    logic [1:0]                 rresp_ff;
    logic [stc_pkg::ADDR_W-1:0] raddr_ff;

    // count path
    logic [DIV_W-1:0]           div_ff;
    logic                       instr_tick;
    logic                       osc_rise;
    logic                       ext_rise;
    logic                       src_tick;
    logic                       psc_tick;
    logic                       sync_tick_ff;
    logic                       inc;
    logic                       do_wr;
    logic                       wr_lo;
    logic                       wr_hi;
    logic                       nxt_aw_held;
    logic                       nxt_w_held;
    logic                       nxt_rvalid;
    logic                       run;
    logic                       ext_mode;
    logic                       sync_dis;
    logic                       osc_en;

    if (DIV_W < 1 || stc_pkg::ADDR_W < 5) begin : g_chk
        $error("divider or address width out of range");
    end

    function automatic logic is_mapped(input logic [stc_pkg::ADDR_W-1:0] a);
        unique case (a)
            stc_pkg::OFS_COUNT_LO, stc_pkg::OFS_COUNT_HI, stc_pkg::OFS_FLAG,
            stc_pkg::OFS_IRQ_EN, stc_pkg::OFS_CTRL, stc_pkg::OFS_PORT_DIR,
            stc_pkg::OFS_PORT_DATA: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    assign run      = ctrl_ff[stc_pkg::CTRL_RUN];
    assign ext_mode = ctrl_ff[stc_pkg::CTRL_CS];
    assign sync_dis = ctrl_ff[stc_pkg::CTRL_SYNC_DIS];
    assign osc_en   = ctrl_ff[stc_pkg::CTRL_OSC_EN];

    // write handshake: address and data are taken in either order
    assign do_wr       = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_lo       = do_wr && wlane_ff && waddr_ff == stc_pkg::OFS_COUNT_LO;
    assign wr_hi       = do_wr && wlane_ff && waddr_ff == stc_pkg::OFS_COUNT_HI;
    assign nxt_aw_held = (aw_held_ff || (awvalid && awready_ff)) && !do_wr;
    assign nxt_w_held  = (w_held_ff || (wvalid && wready_ff)) && !do_wr;
    assign nxt_rvalid  = (rvalid_ff && !rready) || (arvalid && arready_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awready_ff <= !nxt_aw_held;
            wready_ff  <= !nxt_w_held;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waddr_ff <= '0;
            wbyte_ff <= '0;
            wlane_ff <= 1'b0;
        end else begin
            if (awvalid && awready_ff) begin
                waddr_ff <= awaddr;
            end
            if (wvalid && wready_ff) begin
                wbyte_ff <= wdata[7:0];
                wlane_ff <= wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= stc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= is_mapped(waddr_ff) ? stc_pkg::RESP_OKAY : stc_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read side: one outstanding read, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            raddr_ff   <= '0;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (arvalid && arready_ff) begin
                raddr_ff <= araddr;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_ff <= '0;
            rresp_ff <= stc_pkg::RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            rresp_ff <= is_mapped(araddr) ? stc_pkg::RESP_OKAY : stc_pkg::RESP_SLVERR;
            unique case (araddr)
                stc_pkg::OFS_COUNT_LO:  rdata_ff <= {24'h0, count_ff[7:0]};  // RQ1
                stc_pkg::OFS_COUNT_HI:  rdata_ff <= {24'h0, count_ff[15:8]}; // RQ1
                stc_pkg::OFS_FLAG:      rdata_ff <= 32'(flag_ff);
                stc_pkg::OFS_IRQ_EN:    rdata_ff <= 32'(irq_en_ff);
                stc_pkg::OFS_CTRL:      rdata_ff <= {24'h0, ctrl_ff};        // RQ19
                stc_pkg::OFS_PORT_DIR:  rdata_ff <= {24'h0, port_dir_ff, 6'h0};
                stc_pkg::OFS_PORT_DATA: rdata_ff <= {24'h0, port_data_ff, 6'h0};
                default:                rdata_ff <= '0;
            endcase
        end
    end

    // software registers; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff      <= stc_pkg::CTRL_RESET;
            irq_en_ff    <= 1'b0;
            port_dir_ff  <= stc_pkg::PORT_DIR_RESET[7:6];
            port_data_ff <= stc_pkg::PORT_DATA_RESET[7:6];
        end else if (do_wr && wlane_ff) begin
            unique case (waddr_ff)
                stc_pkg::OFS_CTRL:      ctrl_ff <= wbyte_ff & stc_pkg::CTRL_MASK; // RQ19
                stc_pkg::OFS_IRQ_EN:    irq_en_ff <= wbyte_ff[stc_pkg::EN_OVF];
                stc_pkg::OFS_PORT_DIR:  port_dir_ff <= wbyte_ff[7:6];
                stc_pkg::OFS_PORT_DATA: port_data_ff <= wbyte_ff[7:6];
                default: ;
            endcase
        end
    end

    // instruction clock is one aclk in four
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= (div_ff == DIV_W'(stc_pkg::INSTR_DIV - 1)) ? '0 : div_ff + DIV_W'(1);
        end
    end
    assign instr_tick = div_ff == DIV_W'(stc_pkg::INSTR_DIV - 1); // RQ15

    stc_edge_sync u_osc_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (osc_input_pin_in),
        .rise    (osc_rise)
    );

    stc_edge_sync u_ext_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (ext_clock_pin_in),
        .rise    (ext_rise)
    );

    // a stopped timer also freezes its prescaler
    assign src_tick = run && (ext_mode ? (osc_en ? osc_rise : ext_rise) // RQ5 RQ7 RQ16
                                       : instr_tick);                  // RQ6 RQ8

    stc_prescaler #(
        .CNT_W (3)
    ) u_psc (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ratio_sel (ctrl_ff[stc_pkg::CTRL_PSC_HI:stc_pkg::CTRL_PSC_LO]),
        .clear     (wr_lo || wr_hi),
        .tick_in   (src_tick),
        .tick_out  (psc_tick)
    );

    // synchronised mode adds a stage after the prescaler; the pins are always
    // brought onto aclk first, so unsynchronised mode only saves that stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_tick_ff <= 1'b0;
        end else begin
            sync_tick_ff <= psc_tick; // RQ18
        end
    end
    assign inc = run && ((ext_mode && !sync_dis) ? sync_tick_ff : psc_tick); // RQ13 RQ14

    // write beats capture/compare reset, which beats counting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= stc_pkg::COUNT_RESET;
        end else if (wr_lo || wr_hi) begin
            if (wr_lo) count_ff[7:0] <= wbyte_ff;  // RQ1 RQ17
            if (wr_hi) count_ff[15:8] <= wbyte_ff; // RQ1 RQ17
        end else if (cc_reset) begin
            count_ff <= stc_pkg::COUNT_RESET;      // RQ9
        end else if (inc) begin
            count_ff <= count_ff + 16'h0001;       // RQ2
        end
    end

    // overflow set wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff <= 1'b0;
        end else if (inc && !wr_lo && !wr_hi && !cc_reset
                     && count_ff == stc_pkg::COUNT_MAX) begin
            flag_ff <= 1'b1; // RQ3
        end else if (do_wr && wlane_ff && waddr_ff == stc_pkg::OFS_FLAG) begin
            flag_ff <= wbyte_ff[stc_pkg::FLAG_OVF];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= flag_ff && irq_en_ff; // RQ4
        end
    end

    // oe_n high means the pin is an input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe_n_ff <= stc_pkg::PIN_MASK;
            pin_out_ff  <= '0;
        end else begin
            pin_oe_n_ff <= port_dir_ff | {2{osc_en}}; // RQ10
            pin_out_ff  <= port_data_ff;
        end
    end

    assign awready             = awready_ff;
    assign wready              = wready_ff;
    assign bvalid              = bvalid_ff;
    assign bresp               = bresp_ff;
    assign arready             = arready_ff;
    assign rvalid              = rvalid_ff;
    assign rdata               = rdata_ff;
    assign rresp               = rresp_ff;
    assign overflow_irq        = irq_ff;
    assign osc_amp_enable      = ctrl_ff[stc_pkg::CTRL_OSC_EN]; // RQ12
    assign osc_input_pin_oe_n  = pin_oe_n_ff[1];
    assign osc_output_pin_oe_n = pin_oe_n_ff[0];
    assign osc_input_pin_out   = pin_out_ff[1];
    assign osc_output_pin_out  = pin_out_ff[0];

    // checks
    logic wrap;
    assign wrap = inc && !wr_lo && !wr_hi && !cc_reset && count_ff == stc_pkg::COUNT_MAX;

    property p_wrap;
        @(posedge aclk) disable iff (!aresetn) wrap |=> count_ff == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap"); // RQ2

    property p_flag;
        @(posedge aclk) disable iff (!aresetn) wrap |=> flag_ff ##1 irq_ff == irq_en_ff;
    endproperty
    a_flag: assert property (p_flag) else $error("overflow flag missing"); // RQ3

    property p_irq_mask;
        @(posedge aclk) disable iff (!aresetn) !irq_en_ff |=> !irq_ff;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised"); // RQ4

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
            !run && !wr_lo && !wr_hi && !cc_reset |=> $stable(count_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped count moved"); // RQ8

    property p_cc_clr;
        @(posedge aclk) disable iff (!aresetn)
            cc_reset && !wr_lo && !wr_hi |=> count_ff == 16'h0000;
    endproperty
    a_cc_clr: assert property (p_cc_clr) else $error("compare reset ignored"); // RQ9

    property p_wr_wins;
        @(posedge aclk) disable iff (!aresetn)
            wr_lo && cc_reset |=> count_ff[7:0] == $past(wbyte_ff);
    endproperty
    a_wr_wins: assert property (p_wr_wins) else $error("write lost to compare reset"); // RQ17

    property p_osc_in;
        @(posedge aclk) disable iff (!aresetn)
            osc_en |=> osc_input_pin_oe_n && osc_output_pin_oe_n;
    endproperty
    a_osc_in: assert property (p_osc_in) else $error("osc pin driven"); // RQ10

    property p_instr;
        @(posedge aclk) disable iff (!aresetn)
            instr_tick |=> !instr_tick [*3] ##1 instr_tick;
    endproperty
    a_instr: assert property (p_instr) else $error("instruction tick period"); // RQ15

    property p_ctrl_rd;
        @(posedge aclk) disable iff (!aresetn)
            rvalid_ff && raddr_ff == stc_pkg::OFS_CTRL |-> rdata_ff[7:6] == 2'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control top bits set"); // RQ19

    c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) wrap);
    c_cc_clr: cover property (@(posedge aclk) disable iff (!aresetn) cc_reset && run);
    c_ext: cover property (@(posedge aclk) disable iff (!aresetn) inc && ext_mode && !sync_dis);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_ff));
endmodule : stc_timer
`default_nettype wire

// *** dv/stc_pulse_src.sv ***
// pin-side clock source: bursts of rising edges on one pin
// assumes the bench calls burst; the pin stands low between bursts
`timescale 1ns/1ps
`default_nettype none
module stc_pulse_src #(
    parameter int HALF = 3
) (
    // sampling clock
    input  wire logic aclk,
    // pin
    output logic      pin
);
    initial pin = 1'b0;
    // each level lasts HALF cycles, above the two-cycle minimum of the syncs
    task automatic burst(input int n);
        repeat (n) begin
            repeat (HALF) @(posedge aclk);
            pin <= 1'b1;
            repeat (HALF) @(posedge aclk);
            pin <= 1'b0;
        end
    endtask : burst
endmodule : stc_pulse_src
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench of the timer: axi4-lite master, pin sources, scenarios
// assumes stc_pkg and stc_timer are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h1;
    logic [2:0]  prot = 3'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, cc_reset = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic        ext_src, osc_src, in_out, in_oe_n, out_out, out_oe_n, amp, irq;
    wire logic   ext_pin = out_oe_n ? ext_src : out_out;
    wire logic   osc_pin = in_oe_n ? osc_src : in_out;
    int          n_mismatch = 0;
    int          tests_run = 0;

    always #12.5 aclk = ~aclk;

    stc_timer uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(prot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .cc_reset(cc_reset),
        .osc_input_pin_in(osc_pin), .osc_input_pin_out(in_out), .osc_input_pin_oe_n(in_oe_n),
        .ext_clock_pin_in(ext_pin), .osc_output_pin_out(out_out),
        .osc_output_pin_oe_n(out_oe_n), .osc_amp_enable(amp), .overflow_irq(irq));
    stc_pulse_src ext (.aclk(aclk), .pin(ext_src));
    stc_pulse_src osc (.aclk(aclk), .pin(osc_src));

    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic timeout();
        n_mismatch++;
        close_out();
    endtask : timeout

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            k++;
        end while (!bvalid && k < 50);
        r = bresp;
        bready <= 1'b0;
        if (!bvalid) timeout();
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int k;
        k = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            k++;
        end while (!rvalid && k < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (!rvalid) timeout();
    endtask : rd

    task automatic s_regs();
        rd(stc_pkg::OFS_CTRL);
        `CHK(d, 32'h0)
        rd(8'h40);
        `CHK(r, stc_pkg::RESP_SLVERR)
        // a write with lane 0 off is answered but must leave the register alone
        wstrb <= 4'h0;
        prot  <= 3'h7;
        wr(stc_pkg::OFS_CTRL, 8'h01);
        `CHK(r, stc_pkg::RESP_OKAY)
        wstrb <= 4'h1;
        rd(stc_pkg::OFS_CTRL);
        `CHK(d, 32'h0)
        wr(stc_pkg::OFS_COUNT_LO, 8'ha5);
        wr(stc_pkg::OFS_COUNT_HI, 8'h5a);
        rd(stc_pkg::OFS_COUNT_LO);
        `CHK(d, 32'ha5)
        rd(stc_pkg::OFS_COUNT_HI);
        `CHK(d, 32'h5a)
        wr(stc_pkg::OFS_PORT_DIR, 8'h00);
        wr(stc_pkg::OFS_PORT_DATA, 8'hc0);
        repeat (2) @(posedge aclk);
        `CHK({in_out, out_out, in_oe_n, out_oe_n}, 4'b1100)
        wr(stc_pkg::OFS_CTRL, 8'hfc);
        rd(stc_pkg::OFS_CTRL);
        `CHK(d, 32'h3c)
        repeat (3) @(posedge aclk);
        `CHK({amp, in_oe_n, out_oe_n}, 3'b111)
        wr(stc_pkg::OFS_CTRL, 8'h00);
        repeat (3) @(posedge aclk);
        `CHK({amp, in_oe_n, out_oe_n}, 3'b000)
        wr(stc_pkg::OFS_PORT_DIR, 8'hff);
    endtask : s_regs

    // timer mode at every prescale code; the sync bit is toggled and must not matter
    task automatic s_timer();
        logic [7:0] e, h;
        for (int p = 0; p < 4; p++) begin
            wr(stc_pkg::OFS_COUNT_HI, 8'h00);
            wr(stc_pkg::OFS_COUNT_LO, 8'h00);
            wr(stc_pkg::OFS_CTRL, {2'b00, p[1:0], 1'b0, p[0], 2'b01});
            repeat (256) @(posedge aclk);
            wr(stc_pkg::OFS_CTRL, 8'h00);
            rd(stc_pkg::OFS_COUNT_LO);
            e = 8'(256 / (stc_pkg::INSTR_DIV << p));
            h = d[7:0];
            `CHK(h >= e && h <= e + 8'h2, 1'b1)
            repeat (20) @(posedge aclk);
            rd(stc_pkg::OFS_COUNT_LO);
            `CHK(d[7:0], h)
        end
    endtask : s_timer

    task automatic s_ovf();
        wr(stc_pkg::OFS_IRQ_EN, 8'h01);
        wr(stc_pkg::OFS_COUNT_LO, 8'hff);
        wr(stc_pkg::OFS_COUNT_HI, 8'hff);
        wr(stc_pkg::OFS_CTRL, 8'h01);
        repeat (12) @(posedge aclk);
        wr(stc_pkg::OFS_CTRL, 8'h00);
        rd(stc_pkg::OFS_COUNT_HI);
        `CHK(d, 32'h0)
        rd(stc_pkg::OFS_FLAG);
        `CHK(d, 32'h1)
        `CHK(irq, 1'b1)
        wr(stc_pkg::OFS_IRQ_EN, 8'h00);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(stc_pkg::OFS_FLAG, 8'h00);
    endtask : s_ovf

    task automatic s_count();
        wr(stc_pkg::OFS_CTRL, 8'h03);
        wr(stc_pkg::OFS_COUNT_LO, 8'h00);
        fork
            ext.burst(10);
            osc.burst(5);
        join
        repeat (8) @(posedge aclk);
        rd(stc_pkg::OFS_COUNT_LO);
        `CHK(d, 32'ha)
        wr(stc_pkg::OFS_CTRL, 8'h2f);
        wr(stc_pkg::OFS_COUNT_LO, 8'h00);
        fork
            osc.burst(8);
            ext.burst(6);
        join
        repeat (8) @(posedge aclk);
        rd(stc_pkg::OFS_COUNT_LO);
        `CHK(d, 32'h2)
        wr(stc_pkg::OFS_CTRL, 8'h00);
    endtask : s_count

    task automatic s_cc_reset();
        // the pulse is sampled on the edge that performs the count write
        fork
            wr(stc_pkg::OFS_COUNT_LO, 8'h33);
            begin
                repeat (2) @(posedge aclk);
                cc_reset <= 1'b1;
                @(posedge aclk);
                cc_reset <= 1'b0;
            end
        join
        rd(stc_pkg::OFS_COUNT_LO);
        `CHK(d, 32'h33)
        @(posedge aclk);
        cc_reset <= 1'b1;
        @(posedge aclk);
        cc_reset <= 1'b0;
        rd(stc_pkg::OFS_COUNT_LO);
        `CHK(d, 32'h0)
        rd(stc_pkg::OFS_FLAG);
        `CHK(d, 32'h0)
    endtask : s_cc_reset

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs();
        s_timer();
        s_ovf();
        s_count();
        s_cc_reset();
        close_out();
    end
endmodule : tb
`default_nettype wire
